// ==== bench/uafilt_remote_node.sv ====
// Far-side model: the shift engine offering received frames to the filter
`timescale 1ns/1ps
module uafilt_remote_node (
    // Clock
    input wire logic ref_clk,
    // Frame handshake
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_ninth,
    output logic rx_stop_ok
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_ninth = 1'b0;
        rx_stop_ok = 1'b0;
    end

    // Offer one frame and hold it until the edge that samples rx_ready high
    task automatic send(input logic [7:0] d, input logic n, input logic s);
        int i;
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_data <= d;
        rx_ninth <= n;
        rx_stop_ok <= s;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (rx_ready !== 1'b1 && i < 100);
        // Idle lines carry the inverse so a stale frame is never mistaken for a new one
        rx_valid <= 1'b0;
        rx_data <= ~d;
        rx_ninth <= ~n;
        rx_stop_ok <= ~s;
        // A frame that is never taken ends the run as a failure
        if (rx_ready !== 1'b1) begin
            uafilt_top_tb_top.chk("rx_ready", {7'h00, rx_ready}, 8'h01);
            uafilt_top_tb_top.final_report();
        end
    endtask
endmodule

// ==== bench/uafilt_top_tb_top.sv ====
// Self-checking testbench for the mode control and address filter block
`timescale 1ns/1ps
module uafilt_top_tb_top;
    import uafilt_pkg::*;
    logic ref_clk;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic rx_valid, rx_ninth, rx_stop_ok, rx_ready;
    logic [7:0] rx_data;
    logic tx_done = 1'b0;
    logic byte_valid;
    logic [7:0] byte_data;
    logic byte_ready = 1'b1;
    logic [1:0] port_mode;
    logic receive_enable, transmit_ninth_bit, baud_double;
    int error_cnt = 0;
    int compares = 0;
    logic [7:0] v;

    uafilt_top dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ninth(rx_ninth),
        .rx_stop_ok(rx_stop_ok), .rx_ready(rx_ready), .tx_done(tx_done),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
        .port_mode(port_mode), .receive_enable(receive_enable),
        .transmit_ninth_bit(transmit_ninth_bit), .baud_double(baud_double));

    uafilt_remote_node partner_u (.ref_clk(ref_clk), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ninth(rx_ninth),
        .rx_stop_ok(rx_stop_ok));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Bus tasks are entered just after a rising edge and leave just after one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic wait_byte(input logic [7:0] exp);
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (byte_valid === 1'b1 && byte_ready === 1'b1) begin
                chk("byte_data", byte_data, exp);
                return;
            end
        end
        chk("byte_valid wait", 8'h00, 8'h01);
        final_report();
    endtask

    task automatic expect_none();
        repeat (8) begin
            @(posedge ref_clk);
            chk("byte_valid", {7'h00, byte_valid}, 8'h00);
        end
    endtask

    task automatic reset_values();
        logic [7:0] addrs [5] = '{UAFILT_OFF_CONTROL, UAFILT_OFF_POWER, UAFILT_OFF_SLAVE_ADDRESS,
            UAFILT_OFF_SMASK, 8'h55};
        foreach (addrs[i]) begin
            rd(addrs[i], v);
            chk("reset read", v, 8'h00);
        end
        chk("port_mode", {6'h00, port_mode}, 8'h00);
    endtask

    task automatic config_outputs();
        wr(UAFILT_OFF_CONTROL, 8'h18);
        chk("transmit_ninth_bit", {7'h00, transmit_ninth_bit}, 8'h01);
        chk("receive_enable", {7'h00, receive_enable}, 8'h01);
        wr(UAFILT_OFF_POWER, 8'h80);
        chk("baud_double", {7'h00, baud_double}, 8'h01);
        rd(UAFILT_OFF_POWER, v);
        chk("power", v, 8'h80);
        tx_done <= 1'b1;
        @(posedge ref_clk);
        tx_done <= 1'b0;
        @(posedge ref_clk);
        rd(UAFILT_OFF_CONTROL, v);
        chk("control tx done", v, 8'h1a);
        wr(UAFILT_OFF_POWER, 8'h00);
    endtask

    task automatic frame_error();
        wr(UAFILT_OFF_CONTROL, 8'h50);
        partner_u.send(8'ha5, 1'b0, 1'b0);
        wait_byte(8'ha5);
        rd(UAFILT_OFF_CONTROL, v);
        chk("control hidden fe", v, 8'h51);
        wr(UAFILT_OFF_POWER, 8'h40);
        rd(UAFILT_OFF_CONTROL, v);
        chk("control fe shown", v, 8'hd1);
        partner_u.send(8'h3c, 1'b0, 1'b1);
        wait_byte(8'h3c);
        rd(UAFILT_OFF_CONTROL, v);
        chk("control fe kept", v, 8'hd5);
        wr(UAFILT_OFF_CONTROL, 8'h50);
        rd(UAFILT_OFF_CONTROL, v);
        chk("control fe cleared", v, 8'h50);
        chk("port_mode kept", {6'h00, port_mode}, 8'h01);
        // The clear lands on the very edge at which the bad frame leaves the buffer
        partner_u.send(8'h69, 1'b0, 1'b0);
        wr(UAFILT_OFF_CONTROL, 8'h50);
        chk("byte_data", byte_data, 8'h69);
        rd(UAFILT_OFF_CONTROL, v);
        chk("control set wins", v, 8'hd1);
        wr(UAFILT_OFF_CONTROL, 8'hd0);
        chk("port_mode fe write", {6'h00, port_mode}, 8'h01);
        rd(UAFILT_OFF_CONTROL, v);
        chk("control fe written", v, 8'hd0);
        wr(UAFILT_OFF_POWER, 8'h00);
    endtask

    // One frame through the filter with the done flags cleared beforehand
    task automatic run_case(input logic [1:0] m, input logic [7:0] d, input logic n,
        input logic s, input logic acc);
        wr(UAFILT_OFF_CONTROL, {m, 1'b1, 1'b1, 4'h0});
        chk("port_mode", {6'h00, port_mode}, {6'h00, m});
        partner_u.send(d, n, s);
        if (acc) begin
            wait_byte(d);
        end else begin
            expect_none();
        end
        rd(UAFILT_OFF_CONTROL, v);
        chk("rx done", {7'h00, v[0]}, {7'h00, acc});
        chk("bit7 mode", {7'h00, v[7]}, {7'h00, m[1]});
    endtask

    task automatic stall_buffer();
        wr(UAFILT_OFF_CONTROL, 8'h10);
        byte_ready <= 1'b0;
        fork
            begin
                partner_u.send(8'h11, 1'b0, 1'b1);
                partner_u.send(8'h22, 1'b0, 1'b1);
                partner_u.send(8'h33, 1'b0, 1'b1);
            end
            begin
                repeat (20) @(posedge ref_clk);
                chk("rx_ready full", {7'h00, rx_ready}, 8'h00);
                byte_ready <= 1'b1;
                wait_byte(8'h11);
                wait_byte(8'h22);
                wait_byte(8'h33);
            end
        join
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        reset_values();
        config_outputs();
        frame_error();
        wr(UAFILT_OFF_SLAVE_ADDRESS, 8'hc0);
        wr(UAFILT_OFF_SMASK, 8'hfd);
        rd(UAFILT_OFF_SMASK, v);
        chk("mask", v, 8'hfd);
        run_case(2'b01, 8'hc2, 1'b0, 1'b1, 1'b1);
        run_case(2'b01, 8'hc1, 1'b0, 1'b1, 1'b0);
        run_case(2'b01, 8'hfd, 1'b0, 1'b1, 1'b1);
        run_case(2'b01, 8'h7f, 1'b0, 1'b1, 1'b0);
        run_case(2'b01, 8'hc0, 1'b0, 1'b0, 1'b0);
        run_case(2'b10, 8'hc0, 1'b0, 1'b1, 1'b0);
        run_case(2'b10, 8'hc0, 1'b1, 1'b1, 1'b1);
        run_case(2'b10, 8'hff, 1'b1, 1'b1, 1'b1);
        run_case(2'b11, 8'hc2, 1'b1, 1'b1, 1'b1);
        run_case(2'b11, 8'hc1, 1'b1, 1'b1, 1'b0);
        run_case(2'b00, 8'h55, 1'b0, 1'b0, 1'b1);
        stall_buffer();
        final_report();
    end
endmodule

// ==== verilog/uafilt_fifo.sv ====
// Small buffer with valid and ready on both sides for received frames
`timescale 1ns/1ps
module uafilt_fifo #(
    parameter int W = 10,
    parameter int DEPTH = 2,
    parameter int AW = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
            end
            count <= next_count;
            // Flags are registered so both ready and valid come from flip-flops
            in_ready <= next_count != (AW+1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end
endmodule

// ==== verilog/uafilt_pkg.sv ====
// Package of constants and types for the serial mode and address filter block
package uafilt_pkg;
    localparam logic [7:0] UAFILT_OFF_CONTROL = 8'h98;
    localparam logic [7:0] UAFILT_OFF_POWER = 8'h87;
    localparam logic [7:0] UAFILT_OFF_SLAVE_ADDRESS = 8'ha9;
    localparam logic [7:0] UAFILT_OFF_SMASK = 8'hb9;
    localparam logic [7:0] UAFILT_RST_CONTROL = 8'h00;
    localparam logic [7:0] UAFILT_RST_ADDR = 8'h00;
    localparam logic UAFILT_RST_BIT = 1'h0;
    // Control register bit positions
    localparam int UAFILT_B_MODE0_FE = 7;
    localparam int UAFILT_B_MODE1 = 6;
    localparam int UAFILT_B_FILTER = 5;
    localparam int UAFILT_B_RXEN = 4;
    localparam int UAFILT_B_TX9 = 3;
    localparam int UAFILT_B_RX9 = 2;
    localparam int UAFILT_B_TXDONE = 1;
    localparam int UAFILT_B_RXDONE = 0;
    // Power control register bit positions, then the frame buffer depth
    localparam int UAFILT_B_BAUD2 = 7;
    localparam int UAFILT_B_FESEL = 6;
    localparam int UAFILT_FIFO_DEPTH = 2;

    typedef enum logic [1:0] {
        UAFILT_MODE_SHIFT = 2'b00,
        UAFILT_MODE_UART8 = 2'b01,
        UAFILT_MODE_UART9_FIXED = 2'b10,
        UAFILT_MODE_UART9_VAR = 2'b11
    } uafilt_mode_t;
endpackage

// ==== verilog/uafilt_top.sv ====
// Serial port mode control, frame error flag and multiprocessor address filter
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module uafilt_top
    import uafilt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Received frames from the shift engine
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_ninth,
    input wire logic rx_stop_ok,
    output logic rx_ready,
    // Transmit completion from the shift engine
    input wire logic tx_done,
    // Accepted bytes towards the receive buffer
    output logic byte_valid,
    output logic [7:0] byte_data,
    input wire logic byte_ready,
    // Configuration towards the shift engine
    output logic [1:0] port_mode,
    output logic receive_enable,
    output logic transmit_ninth_bit,
    output logic baud_double
);
    logic port_mode_bit0;
    logic port_mode_bit1;
    logic multiproc_filter_enable;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
    logic frame_error_flag;
    logic frame_error_select;
    logic [7:0] slave_address;
    logic [7:0] slave_address_mask;

    logic f_valid;
    logic [7:0] f_data;
    logic f_ninth;
    logic f_stop_ok;
    logic f_pop;
    logic given_hit;
    logic bcast_hit;
    logic addr_hit;
    logic accept;
    logic fe_set;
    logic wr_ctl;
    logic wr_pwr;
    logic [7:0] ctl_read;
    uafilt_mode_t mode;

    uafilt_fifo #(
        .W(10),
        .DEPTH(UAFILT_FIFO_DEPTH),
        .AW(1)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(rx_valid),
        .in_data({rx_stop_ok, rx_ninth, rx_data}),
        .in_ready(rx_ready),
        .out_valid(f_valid),
        .out_data({f_stop_ok, f_ninth, f_data}),
        .out_ready(f_pop)
    );

    assign mode = uafilt_mode_t'({port_mode_bit0, port_mode_bit1});
    assign wr_ctl = reg_wr && (reg_addr == UAFILT_OFF_CONTROL);
    assign wr_pwr = reg_wr && (reg_addr == UAFILT_OFF_POWER);

    // A held output byte stalls the buffer, which in turn stalls the engine
    assign f_pop = f_valid && (!byte_valid || byte_ready);

    assign given_hit = ((f_data ^ slave_address) & slave_address_mask) == 8'h00;
    assign bcast_hit = (~f_data & (slave_address | slave_address_mask)) == 8'h00;
    assign addr_hit = given_hit || bcast_hit;

    always_comb begin
        accept = 1'b0;
        if (f_pop && receive_enable) begin
            case (mode)
                UAFILT_MODE_SHIFT: begin
                    accept = 1'b1;
                end
                UAFILT_MODE_UART8: begin
                    accept = !multiproc_filter_enable || (f_stop_ok && addr_hit);
                end
                default: begin
                    accept = !multiproc_filter_enable || (f_ninth && addr_hit);
                end
            endcase
        end
    end

    // Shift register mode has no stop bit to judge
    assign fe_set = f_pop && (mode != UAFILT_MODE_SHIFT) && !f_stop_ok;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_mode_bit0 <= UAFILT_RST_BIT;
            port_mode_bit1 <= UAFILT_RST_BIT;
            multiproc_filter_enable <= UAFILT_RST_BIT;
            receive_enable <= UAFILT_RST_BIT;
            transmit_ninth_bit <= UAFILT_RST_BIT;
        end else if (wr_ctl) begin
            if (!frame_error_select) begin
                port_mode_bit0 <= reg_wdata[UAFILT_B_MODE0_FE];
            end
            port_mode_bit1 <= reg_wdata[UAFILT_B_MODE1];
            multiproc_filter_enable <= reg_wdata[UAFILT_B_FILTER];
            receive_enable <= reg_wdata[UAFILT_B_RXEN];
            transmit_ninth_bit <= reg_wdata[UAFILT_B_TX9];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_error_flag <= UAFILT_RST_BIT;
        end else if (fe_set) begin
            frame_error_flag <= 1'b1;
        end else if (wr_ctl && frame_error_select) begin
            frame_error_flag <= reg_wdata[UAFILT_B_MODE0_FE];
        end
    end

    // Hardware sets of the done flags win over a software write in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            receive_done_flag <= UAFILT_RST_BIT;
            transmit_done_flag <= UAFILT_RST_BIT;
            received_ninth_bit <= UAFILT_RST_BIT;
        end else begin
            if (accept) begin
                receive_done_flag <= 1'b1;
            end else if (wr_ctl) begin
                receive_done_flag <= reg_wdata[UAFILT_B_RXDONE];
            end
            if (tx_done) begin
                transmit_done_flag <= 1'b1;
            end else if (wr_ctl) begin
                transmit_done_flag <= reg_wdata[UAFILT_B_TXDONE];
            end
            // In 8-bit mode the stored ninth bit is the stop bit
            if (accept && mode != UAFILT_MODE_SHIFT) begin
                received_ninth_bit <= (mode == UAFILT_MODE_UART8) ? f_stop_ok : f_ninth;
            end else if (wr_ctl) begin
                received_ninth_bit <= reg_wdata[UAFILT_B_RX9];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_error_select <= UAFILT_RST_BIT;
            baud_double <= UAFILT_RST_BIT;
            slave_address <= UAFILT_RST_ADDR;
            slave_address_mask <= UAFILT_RST_ADDR;
        end else begin
            if (wr_pwr) begin
                frame_error_select <= reg_wdata[UAFILT_B_FESEL];
                baud_double <= reg_wdata[UAFILT_B_BAUD2];
            end
            if (reg_wr && reg_addr == UAFILT_OFF_SLAVE_ADDRESS) begin
                slave_address <= reg_wdata;
            end
            if (reg_wr && reg_addr == UAFILT_OFF_SMASK) begin
                slave_address_mask <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
        end else begin
            if (accept) begin
                byte_valid <= 1'b1;
                byte_data <= f_data;
            end else if (byte_ready) begin
                byte_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_mode <= UAFILT_MODE_SHIFT;
        end else begin
            port_mode <= {(wr_ctl && !frame_error_select) ? reg_wdata[UAFILT_B_MODE0_FE]
                          : port_mode_bit0, wr_ctl ? reg_wdata[UAFILT_B_MODE1] : port_mode_bit1};
        end
    end

    always_comb begin
        ctl_read = {frame_error_select ? frame_error_flag : port_mode_bit0,
                    port_mode_bit1, multiproc_filter_enable, receive_enable,
                    transmit_ninth_bit, received_ninth_bit, transmit_done_flag,
                    receive_done_flag};
    end

    // Unmapped addresses read as zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                UAFILT_OFF_CONTROL: reg_rdata <= ctl_read;
                UAFILT_OFF_POWER: reg_rdata <= {baud_double, frame_error_select, 6'h00};
                UAFILT_OFF_SLAVE_ADDRESS: reg_rdata <= slave_address;
                UAFILT_OFF_SMASK: reg_rdata <= slave_address_mask;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    sequence seq_addr_frame;
        f_pop && receive_enable && multiproc_filter_enable && !receive_done_flag && !wr_ctl;
    endsequence

    sequence seq_nine_bit_addr;
        seq_addr_frame ##0 mode[1] && f_ninth;
    endsequence

    AST_FE_SET: assert property (@(posedge ref_clk) disable iff (rst)
        fe_set |=> frame_error_flag)
        else $error("frame error not flagged");

    AST_FE_STICKY: assert property (@(posedge ref_clk) disable iff (rst)
        frame_error_flag && !(wr_ctl && frame_error_select) |=> frame_error_flag)
        else $error("frame error flag dropped without a clear");

    AST_FE_READ: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == UAFILT_OFF_CONTROL && frame_error_select
        |=> reg_rdata[7] == $past(frame_error_flag))
        else $error("bit 7 read does not show frame error");

    AST_MODE_READ: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == UAFILT_OFF_CONTROL && !frame_error_select
        |=> reg_rdata[7] == $past(port_mode_bit0))
        else $error("bit 7 read does not show mode bit");

    AST_MODE_OUT: assert property (@(posedge ref_clk) disable iff (rst)
        wr_ctl && !frame_error_select |=> port_mode == $past(reg_wdata[7:6]))
        else $error("mode output does not follow written bits");

    AST_NINE_FILTER: assert property (@(posedge ref_clk) disable iff (rst)
        seq_addr_frame ##0 mode[1] && !(f_ninth && addr_hit) |=> !receive_done_flag)
        else $error("receive done set for non address frame");

    AST_EIGHT_FILTER: assert property (@(posedge ref_clk) disable iff (rst)
        seq_addr_frame ##0 mode == UAFILT_MODE_UART8 && !addr_hit |=> !receive_done_flag)
        else $error("receive done set for foreign address");

    AST_GIVEN: assert property (@(posedge ref_clk) disable iff (rst)
        seq_nine_bit_addr ##0 ((f_data & slave_address_mask) == (slave_address & slave_address_mask))
        |=> receive_done_flag ##0 byte_data == $past(f_data))
        else $error("given address not accepted");

    AST_BCAST: assert property (@(posedge ref_clk) disable iff (rst)
        seq_nine_bit_addr ##0 f_data == 8'hff |=> receive_done_flag)
        else $error("broadcast address not accepted");

    AST_STOP_NEEDED: assert property (@(posedge ref_clk) disable iff (rst)
        seq_addr_frame ##0 mode == UAFILT_MODE_UART8 && !f_stop_ok |=> !receive_done_flag)
        else $error("receive done set without stop bit");

    AST_SHIFT_ALL: assert property (@(posedge ref_clk) disable iff (rst)
        f_pop && receive_enable && mode == UAFILT_MODE_SHIFT |=> receive_done_flag && byte_valid)
        else $error("shift mode byte not accepted");

    AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (rst)
        fe_set && wr_ctl && frame_error_select && !reg_wdata[7] |=> frame_error_flag)
        else $error("clear beat frame error set");
endmodule
